// *** hw/dcpr_pointer_readback.sv ***
// design: per-stream live source/destination pointers behind an axi4-lite slave
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dcpr_pointer_readback
  import dcpr_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = 8
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  // axi4-lite slave
  input  wire logic [ADDR_WIDTH-1:0]  s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]  s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // transfer engine strobes, one bit per stream, same clock
  input  wire logic [NUM_STREAMS-1:0] sourceUnitFetched,
  input  wire logic [NUM_STREAMS-1:0] destinationUnitWritten,
  // live state toward the engine
  output logic [NUM_STREAMS-1:0]      streamEnabled
);

  // the map needs a full stride per stream
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : gAddrCheck
    $error("dcpr_pointer_readback: ADDR_WIDTH must be 8..32");
  end

  // the stream index is two address bits, so the map serves exactly four streams
  if (NUM_STREAMS != 4) begin : gStreamCheck
    $error("dcpr_pointer_readback: NUM_STREAMS must be 4");
  end

  logic [31:0] sourcePointer_q [NUM_STREAMS];
  logic [31:0] destPointer_q [NUM_STREAMS];
  logic [31:0] sourceStart_q [NUM_STREAMS];
  logic [31:0] destStart_q [NUM_STREAMS];
  logic [31:0] control_q [NUM_STREAMS];

  logic [ADDR_WIDTH-1:0] writeAddr_q;
  logic [31:0]           writeData_q;
  logic [3:0]            writeStrb_q;
  logic                  addrHeld_q;
  logic                  dataHeld_q;
  logic                  writeFire;
  logic [1:0]            writeStream;
  logic [5:0]            writeOffset;
  dcpr_access_type       writeKind;
  // decoded write and read targets
  logic                  controlWrite;
  logic [31:0]           controlKeep;
  logic                  readMapped;
  logic [31:0]           readWord;

  // per-stream pointer events, decoded once for the pointer process
  logic [NUM_STREAMS-1:0] transferStart;
  logic [NUM_STREAMS-1:0] sourceStep;
  logic [NUM_STREAMS-1:0] destStep;

  // stream index from a byte address
  function automatic logic [1:0] streamOf(input logic [ADDR_WIDTH-1:0] addr);
    return addr[7:6];
  endfunction

  // offset within the stream window
  function automatic logic [5:0] offsetOf(input logic [ADDR_WIDTH-1:0] addr);
    return addr[5:0];
  endfunction

  // classify an address; bits above the map make it unmapped
  function automatic dcpr_access_type accessOf(input logic [ADDR_WIDTH-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr);
    if (wide[31:8] != 24'h00_0000) begin
      return DCPR_REG_NONE;
    end
    unique case (offsetOf(addr))
      OFS_SOURCE_START,
      OFS_DEST_START,
      OFS_STREAM_CONTROL:           return DCPR_REG_RW;
      OFS_SOURCE_POINTER_HIGH,
      OFS_SOURCE_POINTER_LOW,
      OFS_DESTINATION_POINTER_HIGH,
      OFS_DESTINATION_POINTER_LOW:  return DCPR_REG_RO;
      default:                      return DCPR_REG_NONE;
    endcase
  endfunction

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // unit width in bytes; the reserved code counts as a word
  function automatic logic [31:0] unitBytes(input logic [1:0] code);
    unique case (code)
      UNIT_BYTE: return 32'h0000_0001;
      UNIT_HALF: return 32'h0000_0002;
      default:   return 32'h0000_0004;
    endcase
  endfunction

  // write fires once address and data are both held
  always_comb begin
    writeFire = addrHeld_q && dataHeld_q && !s_axi_bvalid;
    writeStream = streamOf(writeAddr_q);
    writeOffset = offsetOf(writeAddr_q);
    writeKind = accessOf(writeAddr_q);
    controlWrite = writeFire && writeKind == DCPR_REG_RW
                   && writeOffset == OFS_STREAM_CONTROL;
    // mem-to-mem means nothing below the last stream, so it never sticks there
    if (writeStream == 2'(NUM_STREAMS - 1)) begin
      controlKeep = CONTROL_WRITE_MASK;
    end else begin
      controlKeep = CONTROL_WRITE_MASK & ~(32'(1) << BIT_MEM_TO_MEM);
    end
  end

  // transfer start and increment requests per stream
  always_comb begin
    for (int s = 0; s < NUM_STREAMS; s++) begin
      // enable going 0 to 1 through byte lane 0 starts a transfer
      transferStart[s] = controlWrite && writeStream == 2'(s) && writeStrb_q[0]
                         && writeData_q[BIT_ENABLE] && !control_q[s][BIT_ENABLE];
      // strobes on an idle stream are dropped so its halves stay put
      sourceStep[s] = control_q[s][BIT_ENABLE] && sourceUnitFetched[s]
                      && control_q[s][BIT_SOURCE_INCREMENT_ENABLE];
      destStep[s] = control_q[s][BIT_ENABLE] && destinationUnitWritten[s]
                    && control_q[s][BIT_DESTINATION_INCREMENT_ENABLE];
    end
  end

  // write address channel; taken independently of data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addrHeld_q <= 1'b0;
      writeAddr_q <= '0;
      s_axi_awready <= 1'b0;
    end else if (writeFire) begin
      addrHeld_q <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      addrHeld_q <= 1'b1;
      writeAddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      // reopens only once the response is gone: one write at a time
      s_axi_awready <= !addrHeld_q && !s_axi_bvalid;
    end
  end

  // write data channel
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataHeld_q <= 1'b0;
      writeData_q <= '0;
      writeStrb_q <= '0;
      s_axi_wready <= 1'b0;
    end else if (writeFire) begin
      dataHeld_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      dataHeld_q <= 1'b1;
      writeData_q <= s_axi_wdata;
      writeStrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      // data side follows the same rule as the address side
      s_axi_wready <= !dataHeld_q && !s_axi_bvalid;
    end
  end

  // write response; pointer writes answer okay but store nothing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (writeFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (writeKind == DCPR_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      // bready alone clears; harmless while bvalid is already low
      s_axi_bvalid <= 1'b0;
    end
  end

  // stream control and start addresses, software owned
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NUM_STREAMS; s++) begin
        control_q[s] <= CONTROL_RESET;
        sourceStart_q[s] <= START_RESET;
        destStart_q[s] <= START_RESET;
      end
    end else if (writeFire && writeKind == DCPR_REG_RW) begin
      unique case (writeOffset)
        OFS_STREAM_CONTROL: begin
          // reserved bits drop and read back zero
          control_q[writeStream] <= mergeBytes(control_q[writeStream],
                                               writeData_q, writeStrb_q)
                                    & controlKeep;
        end
        OFS_SOURCE_START: begin
          sourceStart_q[writeStream] <= mergeBytes(sourceStart_q[writeStream],
                                                   writeData_q, writeStrb_q);
        end
        default: begin
          destStart_q[writeStream] <= mergeBytes(destStart_q[writeStream],
                                                 writeData_q, writeStrb_q);
        end
      endcase
    end
  end

  // live pointers; only the engine strobes and a transfer start move them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NUM_STREAMS; s++) begin
        sourcePointer_q[s] <= POINTER_RESET;
        destPointer_q[s] <= POINTER_RESET;
      end
    end else begin
      for (int s = 0; s < NUM_STREAMS; s++) begin
        if (transferStart[s]) begin
          // a new transfer reloads both pointers from their start values
          sourcePointer_q[s] <= sourceStart_q[s];
          destPointer_q[s] <= destStart_q[s];
        end else begin
          // the two sides step independently and may both move in one cycle
          if (sourceStep[s]) begin
            sourcePointer_q[s] <= sourcePointer_q[s] + unitBytes(
              control_q[s][POS_SOURCE_UNIT_WIDTH +: 2]);
          end
          if (destStep[s]) begin
            destPointer_q[s] <= destPointer_q[s] + unitBytes(
              control_q[s][POS_DESTINATION_UNIT_WIDTH +: 2]);
          end
        end
      end
    end
  end

  // read value of one register; reserved upper bits read zero
  function automatic logic [31:0] readValue(input logic [ADDR_WIDTH-1:0] addr);
    logic [1:0] s;
    s = streamOf(addr);
    unique case (offsetOf(addr))
      OFS_SOURCE_START:             return sourceStart_q[s];
      OFS_DEST_START:               return destStart_q[s];
      OFS_STREAM_CONTROL:           return control_q[s];
      OFS_SOURCE_POINTER_HIGH:      return {16'h0000,
                                            sourcePointer_q[s][31:HALF_WIDTH]};
      OFS_SOURCE_POINTER_LOW:       return {16'h0000,
                                            sourcePointer_q[s][HALF_WIDTH-1:0]};
      OFS_DESTINATION_POINTER_HIGH: return {16'h0000,
                                            destPointer_q[s][31:HALF_WIDTH]};
      OFS_DESTINATION_POINTER_LOW:  return {16'h0000,
                                            destPointer_q[s][HALF_WIDTH-1:0]};
      default:                      return 32'h0000_0000;
    endcase
  endfunction

  // read decode from the live address; only used at the address handshake
  always_comb begin
    readMapped = accessOf(s_axi_araddr) != DCPR_REG_NONE;
    readWord = readValue(s_axi_araddr);
  end

  // read channel; one read outstanding, data captured at the address handshake
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (!readMapped) begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end else begin
        // a read never touches pointer state
        s_axi_rdata <= readWord;
        s_axi_rresp <= RESP_OKAY;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      // one idle cycle after each answer before the next address is taken
      s_axi_arready <= 1'b1;
    end
  end

  // enable bits toward the engine, from a flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      streamEnabled <= '0;
    end else begin
      for (int s = 0; s < NUM_STREAMS; s++) begin
        streamEnabled[s] <= control_q[s][BIT_ENABLE];
      end
    end
  end

endmodule
`default_nettype wire

// *** include/dcpr_pkg.sv ***
// package: register map, field layout and reset values of the pointer readback block
package dcpr_pkg;
  localparam int unsigned NUM_STREAMS = 4;
  localparam int unsigned STREAM_STRIDE = 32'h0000_0040;
  // per-stream register offsets from stream_base_offset
  localparam logic [5:0] OFS_SOURCE_START = 6'h00;
  localparam logic [5:0] OFS_DEST_START = 6'h08;
  localparam logic [5:0] OFS_STREAM_CONTROL = 6'h14;
  localparam logic [5:0] OFS_SOURCE_POINTER_HIGH = 6'h18;
  localparam logic [5:0] OFS_SOURCE_POINTER_LOW = 6'h1C;
  localparam logic [5:0] OFS_DESTINATION_POINTER_HIGH = 6'h20;
  localparam logic [5:0] OFS_DESTINATION_POINTER_LOW = 6'h24;
  // stream_control field positions
  localparam int unsigned BIT_ENABLE = 0;
  localparam int unsigned BIT_SOURCE_INCREMENT_ENABLE = 1;
  localparam int unsigned BIT_DESTINATION_INCREMENT_ENABLE = 2;
  localparam int unsigned POS_SOURCE_UNIT_WIDTH = 3;
  localparam int unsigned POS_DESTINATION_UNIT_WIDTH = 7;
  localparam int unsigned BIT_MEM_TO_MEM = 11;
  localparam int unsigned HALF_WIDTH = 16;
  // writable bits of stream_control, bit 11 on the last stream only; the rest are reserved and read zero
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_2BFF;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] POINTER_RESET = 32'h0000_0000;
  localparam logic [31:0] START_RESET = 32'h0000_0000;
  // unit width encodings
  localparam logic [1:0] UNIT_BYTE = 2'h0;
  localparam logic [1:0] UNIT_HALF = 2'h1;
  localparam logic [1:0] UNIT_WORD = 2'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    DCPR_REG_NONE = 2'b00,
    DCPR_REG_RW   = 2'b01,
    DCPR_REG_RO   = 2'b10
  } dcpr_access_type;
endpackage

// *** tb/dcpr_pointer_readback_asserts.sv ***
// checker: bus handshake and pointer readback properties of the readback block
`timescale 1ns/1ps
`default_nettype none
module dcpr_pointer_readback_asserts
  import dcpr_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = 8
) (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready
);
  logic [5:0] arOfs_q;
  logic [5:0] awOfs_q;
  // offsets kept so a response can be tied to the register it answers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) arOfs_q <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready) arOfs_q <= s_axi_araddr[5:0];
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) awOfs_q <= 6'h00;
    else if (s_axi_awvalid && s_axi_awready) awOfs_q <= s_axi_awaddr[5:0];
  end
  function automatic logic isPtr(input logic [5:0] o);
    return o inside {6'h18, 6'h1C, 6'h20, 6'h24};
  endfunction
  function automatic logic isMapped(input logic [5:0] o);
    return isPtr(o) || (o inside {6'h00, 6'h08, 6'h14});
  endfunction
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence writeTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence readTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_read_answer: assert property (readTaken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not on the next cycle");
  a_write_answer: assert property (writeTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response moved");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_ptr_upper_zero: assert property (s_axi_rvalid && isPtr(arOfs_q) |->
    s_axi_rresp == RESP_OKAY && s_axi_rdata[31:16] == 16'h0000) else $error("pointer read bad");
  a_ptr_write_ok: assert property (s_axi_bvalid && isPtr(awOfs_q) |->
    s_axi_bresp == RESP_OKAY) else $error("pointer write not okay");
  a_unmapped_err: assert property (s_axi_rvalid && !isMapped(arOfs_q) |->
    s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
endmodule
bind dcpr_pointer_readback dcpr_pointer_readback_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
  .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// *** tb/dcpr_pointer_readback_tb.sv ***
// testbench: table-driven register checks and pointer advance scenarios
`timescale 1ns/1ps
`default_nettype none
module dcpr_pointer_readback_tb
  import dcpr_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [31:0] expd;
    logic [1:0]  resp;
  } dcpr_row_type;
  logic         clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic         s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic         s_axi_rvalid;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rdVal, src, dst;
  logic [3:0]   s_axi_wstrb, sourceUnitFetched, destinationUnitWritten, streamEnabled;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rdResp;
  int           n_mismatch, checks_done, s, w;
  dcpr_row_type rows [12];
  dcpr_pointer_readback #(.ADDR_WIDTH(8)) dut_u (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sourceUnitFetched, .destinationUnitWritten, .streamEnabled);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ready goes up with the request and stays up; the slave answers when it will
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    bit fin;
    fin = 0;
    s_axi_bready <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 50 && !fin; n++) begin
      @(posedge clock);
      if (s_axi_bready && s_axi_bvalid === 1'b1) begin
        rdResp = s_axi_bresp;
        fin = 1;
      end
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    if (!fin) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic axiRead(input logic [7:0] a);
    bit fin;
    fin = 0;
    s_axi_rready <= 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 50 && !fin; n++) begin
      @(posedge clock);
      if (s_axi_rready && s_axi_rvalid === 1'b1) begin
        rdVal = s_axi_rdata;
        rdResp = s_axi_rresp;
        fin = 1;
      end
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    if (!fin) begin
      n_mismatch++;
      results();
    end
  endtask
  // reads both halves of one pointer; a is the upper-half address
  task automatic ptrChk(input logic [7:0] a, input logic [31:0] p);
    axiRead(a);
    check("upper half", rdVal, {16'h0000, p[31:16]});
    axiRead(a + 8'h04);
    check("lower half", rdVal, {16'h0000, p[15:0]});
  endtask
  task automatic pulse(input logic [3:0] sf, input logic [3:0] dw);
    @(posedge clock);
    sourceUnitFetched <= sf;
    destinationUnitWritten <= dw;
    @(posedge clock);
    sourceUnitFetched <= 4'h0;
    destinationUnitWritten <= 4'h0;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {sourceUnitFetched, destinationUnitWritten} = 8'h00;
    n_mismatch = 0;
    checks_done = 0;
    // stream 1: start values, then enable with half source and word destination units
    rows = '{'{1'b1, 8'h40, 32'hA5A5_FFFE, 32'h0, RESP_OKAY},
             '{1'b1, 8'h48, 32'h1357_FFFF, 32'h0, RESP_OKAY},
             '{1'b1, 8'h54, 32'h0000_010F, 32'h0, RESP_OKAY},
             '{1'b0, 8'h58, 32'h0, 32'h0000_A5A5, RESP_OKAY},
             '{1'b0, 8'h5C, 32'h0, 32'h0000_FFFE, RESP_OKAY},
             '{1'b0, 8'h60, 32'h0, 32'h0000_1357, RESP_OKAY},
             '{1'b0, 8'h64, 32'h0, 32'h0000_FFFF, RESP_OKAY},
             '{1'b1, 8'h58, 32'h0000_FFFF, 32'h0, RESP_OKAY}, // upper bits left clear
             '{1'b0, 8'h58, 32'h0, 32'h0000_A5A5, RESP_OKAY},
             '{1'b0, 8'h44, 32'h0, 32'h0, RESP_SLVERR},
             '{1'b1, 8'h44, 32'h1234_5678, 32'h0, RESP_SLVERR},
             '{1'b0, 8'h54, 32'h0, 32'h0000_010F, RESP_OKAY}};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (s = 0; s < 4; s++) begin
      ptrChk(8'(s * 64) + 8'h18, 32'h0);
      ptrChk(8'(s * 64) + 8'h20, 32'h0);
    end
    foreach (rows[i]) begin
      if (rows[i].wr) axiWrite(rows[i].addr, rows[i].data, 4'hF);
      else axiRead(rows[i].addr);
      check("resp", {30'h0, rdResp}, {30'h0, rows[i].resp});
      if (!rows[i].wr && rows[i].resp == RESP_OKAY) check("rdata", rdVal, rows[i].expd);
    end
    check("streamEnabled", {28'h0, streamEnabled}, 32'h2);
    // a half-width step carries from the lower half into the upper half
    pulse(4'h2, 4'h2);
    src = 32'hA5A6_0000;
    dst = 32'h1358_0003;
    ptrChk(8'h58, src);
    ptrChk(8'h60, dst);
    // every source width code while enabled; no reload since enable stays set
    for (w = 0; w < 4; w++) begin
      axiWrite(8'h54, 32'(3 + w * 8), 4'h1);
      pulse(4'h2, 4'h0);
      src += (w == 0) ? 1 : (w == 1) ? 2 : 4;
      ptrChk(8'h58, src);
    end
    // increments off: strobes leave both pointers alone
    axiWrite(8'h54, 32'h0000_0001, 4'h1);
    pulse(4'h2, 4'h2);
    ptrChk(8'h58, src);
    ptrChk(8'h60, dst);
    // destination only, byte units
    axiWrite(8'h54, 32'h0000_0005, 4'h3);
    pulse(4'h2, 4'h2);
    dst += 1;
    ptrChk(8'h58, src);
    ptrChk(8'h60, dst);
    // stream disabled: strobes ignored, repeated half reads agree
    axiWrite(8'h54, 32'h0000_0006, 4'h1);
    pulse(4'h2, 4'h2);
    ptrChk(8'h58, src);
    ptrChk(8'h58, src);
    ptrChk(8'h60, dst);
    ptrChk(8'h98, 32'h0);
    // reset in mid-run clears the pointers again
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    ptrChk(8'h58, 32'h0);
    ptrChk(8'h60, 32'h0);
    results();
  end
endmodule
`default_nettype wire
